//--- tgc_pkg.sv
// Summary of operation
// R1: both bits set: external square wave sources tone
// R2: mode bit clear, enable set: input gates carrier
// R3: continuous tone: input high, enable bit switches
// R4: external mode output follows input frequency, duty
// R5: host sets both bits before square wave
// R6: external mode tone starts about 1 us
// R7: external mode tone stops 60 us after
// R8: soft start 4 ms low, 6 ms high
// R9: status at 0x0-0x1, control 0x2-0x5
// R10: envelope start 6 us, stop 15-60 us
// R11: enable bit clear means no tone ever
`default_nettype none
package tgc_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TONE_HZ = 22_000;
  localparam int unsigned TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
  localparam int unsigned EXT_START_NS = 1_000;
  localparam int unsigned EXT_STOP_US = 60;
  localparam int unsigned ENV_START_US = 6;
  localparam int unsigned ENV_STOP_US = 15;
  localparam int unsigned RAMP_LOW_MS = 4;
  localparam int unsigned RAMP_HIGH_MS = 6;
  localparam int unsigned EXT_START_CYC = (EXT_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned EXT_STOP_CYC = (EXT_STOP_US * (CLK_HZ / 1_000_000));
  localparam int unsigned ENV_START_CYC = (ENV_START_US * (CLK_HZ / 1_000_000));
  localparam int unsigned ENV_STOP_CYC = (ENV_STOP_US * (CLK_HZ / 1_000_000));
  localparam int unsigned RAMP_LOW_CYC = RAMP_LOW_MS * (CLK_HZ / 1_000);
  localparam int unsigned RAMP_HIGH_CYC = RAMP_HIGH_MS * (CLK_HZ / 1_000);
  localparam int TIMER_W = 12;
  localparam int RAMP_W = 20;
  // device register map
  localparam logic [7:0] FAULT_FLAGS_A_ADDR = 8'h00;
  localparam logic [7:0] FAULT_FLAGS_B_ADDR = 8'h01;
  localparam logic [7:0] CONTROL_WORD_A_ADDR = 8'h02;
  localparam logic [7:0] CONTROL_WORD_B_ADDR = 8'h03;
  localparam logic [7:0] CONTROL_WORD_C_ADDR = 8'h04;
  localparam logic [7:0] CONTROL_WORD_D_ADDR = 8'h05;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // control_word_a fields
  localparam int OUT_EN_BIT = 0;
  localparam int LEVEL_HIGH_BIT = 1;
  // control_word_b fields
  localparam int EXT_TONE_MODE_BIT = 0;
  localparam int TONE_ON_BIT = 1;
  // fault_flags_a fields
  localparam int ST_TONE_BIT = 0;
  localparam int ST_RAMPING_BIT = 1;
  localparam int ST_GATE_BIT = 2;
  // fault_flags_b fields
  localparam int ST_READY_BIT = 0;
  // host controller map
  localparam logic [7:0] HOST_MODE_ADDR = 8'h00;
  localparam logic [7:0] HOST_STATUS_ADDR = 8'h01;
  localparam logic [7:0] HOST_FWD_BASE = 8'h10;
  localparam logic [7:0] HOST_FWD_LAST = 8'h15;
  localparam int HM_GO_BIT = 2;
  localparam int HM_ENV_LEVEL_BIT = 3;
  localparam logic [7:0] HOST_MODE_RESET = 8'h00;

  typedef enum logic [1:0] {
    TGC_MODE_OFF = 2'h0,
    TGC_MODE_EXT = 2'h1,
    TGC_MODE_ENV = 2'h2,
    TGC_MODE_CONT = 2'h3
  } tgc_mode_t;

  typedef enum logic [1:0] {
    TGC_GATE_OFF = 2'h0,
    TGC_GATE_STARTING = 2'h1,
    TGC_GATE_ON = 2'h2
  } tgc_gate_t;

  typedef enum logic [1:0] {
    TGC_H_IDLE = 2'h0,
    TGC_H_SETUP = 2'h1,
    TGC_H_RUN = 2'h2,
    TGC_H_STOP = 2'h3
  } tgc_hstate_t;
endpackage : tgc_pkg
`default_nettype wire

//--- tgc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface tgc_if;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic tone_control_input;

  modport host (
    output reg_addr,
    output reg_wdata,
    output reg_wr,
    output reg_rd,
    input reg_rdata,
    output tone_control_input
  );

  modport dev (
    input reg_addr,
    input reg_wdata,
    input reg_wr,
    input reg_rd,
    output reg_rdata,
    input tone_control_input
  );
endinterface : tgc_if
`default_nettype wire

//--- tgc_device.sv
`timescale 1ns/1ns
`default_nettype none
module tgc_device
  import tgc_pkg::*;
#(
  parameter int unsigned RAMP_LOW_CYCLES = RAMP_LOW_CYC,
  parameter int unsigned RAMP_HIGH_CYCLES = RAMP_HIGH_CYC
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  tgc_if.dev link,
  output logic regulated_output_tone_out,
  output logic regulated_output_ramping_out,
  output logic regulated_output_ready_out,
  output logic regulated_output_high_out
);
  function automatic logic is_control(input logic [7:0] a);
    is_control = (a >= CONTROL_WORD_A_ADDR) && (a <= CONTROL_WORD_D_ADDR);
  endfunction : is_control

  logic [7:0] ctrl_reg [0:3];
  logic [7:0] rdata_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  tgc_gate_t gate_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic [TIMER_W-1:0] half_cnt_reg;
  logic carrier_reg;
  logic tone_reg;
  logic [RAMP_W-1:0] ramp_cnt_reg;
  logic ramping_reg;
  logic ready_reg;
  logic en_prev_reg;
  logic hi_prev_reg;

  logic [1:0] ctrl_idx;
  logic tone_on_bit;
  logic external_tone_mode;
  logic in_edge;
  logic activity;
  logic [TIMER_W-1:0] start_cyc;
  logic [TIMER_W-1:0] stop_cyc;
  logic out_en;
  logic out_high;
  logic [RAMP_W-1:0] ramp_target;
  logic ramp_restart;

  assign ctrl_idx = 2'(link.reg_addr - CONTROL_WORD_A_ADDR);
  assign tone_on_bit = ctrl_reg[1][TONE_ON_BIT];
  assign external_tone_mode = ctrl_reg[1][EXT_TONE_MODE_BIT];
  assign in_edge = sync2_reg ^ prev_reg;
  // square wave is detected by its edges, an envelope by its level
  assign activity = external_tone_mode ? in_edge : sync2_reg; // see R1 see R2
  assign start_cyc = external_tone_mode ? TIMER_W'(EXT_START_CYC) : TIMER_W'(ENV_START_CYC); // see R6 see R10
  assign stop_cyc = external_tone_mode ? TIMER_W'(EXT_STOP_CYC) : TIMER_W'(ENV_STOP_CYC); // see R7 see R10
  assign out_en = ctrl_reg[0][OUT_EN_BIT];
  assign out_high = ctrl_reg[0][LEVEL_HIGH_BIT];
  assign ramp_target = out_high ? RAMP_W'(RAMP_HIGH_CYCLES - 1) : RAMP_W'(RAMP_LOW_CYCLES - 1); // see R8
  assign ramp_restart = out_en && (!en_prev_reg || (out_high != hi_prev_reg));

  // control registers, all cleared at reset so the output starts disabled
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ctrl
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          ctrl_reg[gi] <= CONTROL_RESET;
        end else if (link.reg_wr && is_control(link.reg_addr) && (ctrl_idx == 2'(gi))) begin // see R9
          ctrl_reg[gi] <= link.reg_wdata;
        end
      end
    end
  endgenerate

  // read data valid only in the cycle after the strobe, zero elsewhere
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_reg <= 8'h00;
    end else if (link.reg_rd) begin
      if (link.reg_addr == FAULT_FLAGS_A_ADDR) begin // see R9
        rdata_reg <= {5'h00, (gate_reg == TGC_GATE_ON), ramping_reg, tone_reg};
      end else if (link.reg_addr == FAULT_FLAGS_B_ADDR) begin
        rdata_reg <= {7'h00, ready_reg};
      end else if (is_control(link.reg_addr)) begin
        rdata_reg <= ctrl_reg[ctrl_idx];
      end else begin
        rdata_reg <= 8'h00;
      end
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // tone line is asynchronous to this clock
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= link.tone_control_input;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // internal carrier, halted while the enable bit is clear
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      half_cnt_reg <= '0;
      carrier_reg <= 1'b0;
    end else if (!tone_on_bit) begin
      half_cnt_reg <= '0;
      carrier_reg <= 1'b0;
    end else if (half_cnt_reg == TIMER_W'(TONE_HALF_CYC - 1)) begin
      half_cnt_reg <= '0;
      carrier_reg <= ~carrier_reg;
    end else begin
      half_cnt_reg <= half_cnt_reg + 1'b1;
    end
  end

  // gate: start delay after first activity, stop delay after last activity
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gate_reg <= TGC_GATE_OFF;
      timer_reg <= '0;
    end else if (!tone_on_bit) begin // see R11
      gate_reg <= TGC_GATE_OFF;
      timer_reg <= '0;
    end else begin
      case (gate_reg)
        TGC_GATE_OFF: begin
          timer_reg <= '0;
          if (activity) begin
            gate_reg <= TGC_GATE_STARTING;
          end
        end
        TGC_GATE_STARTING: begin
          if (!external_tone_mode && !sync2_reg) begin
            gate_reg <= TGC_GATE_OFF; // envelope pulse shorter than the start delay
            timer_reg <= '0;
          end else if (timer_reg >= start_cyc - 1'b1) begin
            gate_reg <= TGC_GATE_ON; // see R6 see R10
            timer_reg <= '0;
          end else begin
            timer_reg <= timer_reg + 1'b1;
          end
        end
        TGC_GATE_ON: begin
          if (activity) begin
            timer_reg <= '0;
          end else if (timer_reg >= stop_cyc - 1'b1) begin
            gate_reg <= TGC_GATE_OFF; // see R7 see R10
            timer_reg <= '0;
          end else begin
            timer_reg <= timer_reg + 1'b1;
          end
        end
        default: begin
          gate_reg <= TGC_GATE_OFF;
          timer_reg <= '0;
        end
      endcase
    end
  end

  // external mode passes the line itself so frequency and duty follow it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tone_reg <= 1'b0;
    end else if (tone_on_bit && (gate_reg == TGC_GATE_ON)) begin // see R11 see R3
      tone_reg <= external_tone_mode ? sync2_reg : carrier_reg; // see R4 see R1 see R2
    end else begin
      tone_reg <= 1'b0;
    end
  end

  // soft start: restarts from zero on enable or level change
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ramp_cnt_reg <= '0;
      ramping_reg <= 1'b0;
      ready_reg <= 1'b0;
      en_prev_reg <= 1'b0;
      hi_prev_reg <= 1'b0;
    end else begin
      en_prev_reg <= out_en;
      hi_prev_reg <= out_high;
      if (!out_en) begin
        ramp_cnt_reg <= '0;
        ramping_reg <= 1'b0;
        ready_reg <= 1'b0;
      end else if (ramp_restart) begin
        ramp_cnt_reg <= '0;
        ramping_reg <= 1'b1;
        ready_reg <= 1'b0;
      end else if (ramping_reg) begin
        if (ramp_cnt_reg >= ramp_target) begin // see R8
          ramping_reg <= 1'b0;
          ready_reg <= 1'b1;
        end else begin
          ramp_cnt_reg <= ramp_cnt_reg + 1'b1;
        end
      end
    end
  end

  assign link.reg_rdata = rdata_reg;
  assign regulated_output_tone_out = tone_reg;
  assign regulated_output_ramping_out = ramping_reg;
  assign regulated_output_ready_out = ready_reg;
  assign regulated_output_high_out = hi_prev_reg && ready_reg;
endmodule : tgc_device
`default_nettype wire

//--- tgc_host.sv
`timescale 1ns/1ns
`default_nettype none
module tgc_host
  import tgc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  tgc_if.host link,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out
);
  function automatic logic is_fwd(input logic [7:0] a);
    is_fwd = (a >= HOST_FWD_BASE) && (a <= HOST_FWD_LAST);
  endfunction : is_fwd

  tgc_hstate_t state_reg;
  logic [7:0] mode_reg;
  logic [7:0] rdata_reg;
  logic fwd_rd_reg;
  logic line_reg;
  logic [TIMER_W-1:0] half_cnt_reg;
  logic sq_reg;

  tgc_mode_t mode;
  logic go;
  logic fsm_wr;
  logic [7:0] fsm_data;

  assign mode = tgc_mode_t'(mode_reg[1:0]);
  assign go = mode_reg[HM_GO_BIT];
  assign fsm_wr = (state_reg == TGC_H_SETUP) || (state_reg == TGC_H_STOP);
  // both tone bits are written in one cycle before the line moves
  assign fsm_data = (state_reg == TGC_H_SETUP) ?
                    {6'h00, 1'b1, (mode == TGC_MODE_EXT)} : 8'h00; // see R5 see R1 see R2 see R3

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_reg <= HOST_MODE_RESET;
    end else if (wr_in && (addr_in == HOST_MODE_ADDR)) begin
      mode_reg <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= TGC_H_IDLE;
    end else begin
      case (state_reg)
        TGC_H_IDLE: begin
          if (go && (mode != TGC_MODE_OFF)) begin
            state_reg <= TGC_H_SETUP;
          end
        end
        TGC_H_SETUP: begin
          state_reg <= TGC_H_RUN;
        end
        TGC_H_RUN: begin
          if (!go || (mode == TGC_MODE_OFF)) begin
            state_reg <= TGC_H_STOP;
          end
        end
        TGC_H_STOP: begin
          state_reg <= TGC_H_IDLE;
        end
        default: begin
          state_reg <= TGC_H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      half_cnt_reg <= '0;
      sq_reg <= 1'b0;
    end else if ((state_reg != TGC_H_RUN) || (mode != TGC_MODE_EXT)) begin
      half_cnt_reg <= '0;
      sq_reg <= 1'b0;
    end else if (half_cnt_reg == TIMER_W'(TONE_HALF_CYC - 1)) begin
      half_cnt_reg <= '0;
      sq_reg <= ~sq_reg;
    end else begin
      half_cnt_reg <= half_cnt_reg + 1'b1;
    end
  end

  // line moves only in run, after the bits were written
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      line_reg <= 1'b0;
    end else if (state_reg == TGC_H_RUN) begin
      case (mode)
        TGC_MODE_EXT: line_reg <= sq_reg; // see R5
        TGC_MODE_ENV: line_reg <= mode_reg[HM_ENV_LEVEL_BIT]; // see R2
        TGC_MODE_CONT: line_reg <= 1'b1; // see R3
        default: line_reg <= 1'b0;
      endcase
    end else if ((state_reg == TGC_H_STOP) && (mode == TGC_MODE_CONT)) begin
      line_reg <= 1'b1; // continuous tone is switched off by the enable bit alone
    end else begin
      line_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_reg <= 8'h00;
      fwd_rd_reg <= 1'b0;
    end else begin
      fwd_rd_reg <= rd_in && is_fwd(addr_in);
      if (rd_in && (addr_in == HOST_MODE_ADDR)) begin
        rdata_reg <= mode_reg;
      end else if (rd_in && (addr_in == HOST_STATUS_ADDR)) begin
        rdata_reg <= {5'h00, line_reg, state_reg};
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  // forwarded writes are dropped in the two cycles the sequencer owns the bus
  assign link.reg_wr = fsm_wr || (wr_in && is_fwd(addr_in));
  assign link.reg_rd = !fsm_wr && rd_in && is_fwd(addr_in);
  assign link.reg_addr = fsm_wr ? CONTROL_WORD_B_ADDR : 8'(addr_in - HOST_FWD_BASE);
  assign link.reg_wdata = fsm_wr ? fsm_data : wdata_in;
  assign link.tone_control_input = line_reg;
  assign rdata_out = fwd_rd_reg ? link.reg_rdata : rdata_reg;
endmodule : tgc_host
`default_nettype wire

//--- tgc_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module tgc_assertions
  import tgc_pkg::*;
#(
  parameter int unsigned RAMP_LOW_CYCLES = 100,
  parameter int unsigned RAMP_HIGH_CYCLES = 150
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tone_control_input,
  input wire logic regulated_output_tone_out,
  input wire logic regulated_output_ramping_out,
  input wire logic regulated_output_ready_out
);
  logic [7:0] ctl_reg [2:5];
  logic [11:0] quiet_reg, high_reg, low_reg;
  logic [19:0] ramp_reg;
  logic line_reg;
  logic ext_q, env_q, ton_q;
  assign ton_q = ctl_reg[3][TONE_ON_BIT];
  assign ext_q = ctl_reg[3][EXT_TONE_MODE_BIT] & ton_q;
  assign env_q = ~ctl_reg[3][EXT_TONE_MODE_BIT] & ton_q;

  // shadow of the control words, so read-back is judged without the design
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 2; i <= 5; i++) ctl_reg[i] <= CONTROL_RESET;
    end else if (reg_wr && reg_addr >= 8'h02 && reg_addr <= 8'h05) begin
      ctl_reg[reg_addr[2:0]] <= reg_wdata;
    end
  end

  // saturating counters, except ramp_reg: too wide a count would wrap and hide a late stop
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      line_reg <= 1'b0;
      quiet_reg <= 12'h000;
      high_reg <= 12'h000;
      low_reg <= 12'h000;
      ramp_reg <= 20'h00000;
    end else begin
      line_reg <= tone_control_input;
      quiet_reg <= (tone_control_input != line_reg) ? 12'h000 : quiet_reg + {11'h000, ~&quiet_reg};
      high_reg <= tone_control_input ? high_reg + {11'h000, ~&high_reg} : 12'h000;
      low_reg <= tone_control_input ? 12'h000 : low_reg + {11'h000, ~&low_reg};
      ramp_reg <= regulated_output_ramping_out ? ramp_reg + 20'h00001 : 20'h00000;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_rd_ctl;
    reg_rd && reg_addr >= 8'h02 && reg_addr <= 8'h05;
  endsequence
  property p_rdback;
    s_rd_ctl |=> reg_rdata == ctl_reg[$past(reg_addr[2:0])];
  endproperty
  a_rdback: assert property (p_rdback) else $error("control read-back wrong");
  property p_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  property p_stat_a;
    reg_rd && reg_addr == FAULT_FLAGS_A_ADDR |=> reg_rdata[7:3] == 5'h00
      && reg_rdata[ST_TONE_BIT] == $past(regulated_output_tone_out)
      && reg_rdata[ST_RAMPING_BIT] == $past(regulated_output_ramping_out);
  endproperty
  a_stat_a: assert property (p_stat_a) else $error("first status byte wrong");
  property p_stat_b;
    reg_rd && reg_addr == FAULT_FLAGS_B_ADDR |=> reg_rdata == {7'h00, $past(regulated_output_ready_out)};
  endproperty
  a_stat_b: assert property (p_stat_b) else $error("second status byte wrong");
  property p_off;
    !ton_q && !$past(ton_q) |-> !regulated_output_tone_out;
  endproperty
  a_off: assert property (p_off) else $error("tone while disabled");
  property p_ext_follow;
    ext_q && $past(ext_q, 3) && regulated_output_tone_out |-> $past(tone_control_input, 3);
  endproperty
  a_ext_follow: assert property (p_ext_follow) else $error("tone not following line");
  property p_ext_start;
    ext_q && $rose(tone_control_input) |-> ##[1:56] (regulated_output_tone_out || !ext_q);
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("square mode start late");
  property p_ext_stop;
    ext_q && regulated_output_tone_out |-> quiet_reg <= 12'd3010;
  endproperty
  a_ext_stop: assert property (p_ext_stop) else $error("square mode stop late");
  property p_env_start;
    env_q && tone_control_input && $rose(regulated_output_tone_out) |-> high_reg >= 12'd300;
  endproperty
  a_env_start: assert property (p_env_start) else $error("envelope start early");
  property p_env_stop;
    env_q && regulated_output_tone_out |-> low_reg <= 12'd760;
  endproperty
  a_env_stop: assert property (p_env_stop) else $error("envelope stop late");
  property p_ramp;
    $rose(regulated_output_ready_out) |-> (ramp_reg + 1 >= RAMP_LOW_CYCLES && ramp_reg <= RAMP_LOW_CYCLES + 1)
      || (ramp_reg + 1 >= RAMP_HIGH_CYCLES && ramp_reg <= RAMP_HIGH_CYCLES + 1);
  endproperty
  a_ramp: assert property (p_ramp) else $error("soft start length wrong");
endmodule : tgc_assertions
`default_nettype wire

//--- tone_gating_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tone_gating_control_tb
  import tgc_pkg::*;
;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out, rv;
  logic tone, ramping, ready, high;
  int err_count = 0;
  int comparisons = 0;
  int n;
  tgc_if link ();
  tgc_host i_tgc_host (.clk_in(clk_in), .rstn_in(rstn_in), .link(link.host), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));
  tgc_device #(.RAMP_LOW_CYCLES(100), .RAMP_HIGH_CYCLES(150)) i_tgc_device (.clk_in(clk_in),
    .rstn_in(rstn_in), .link(link.dev), .regulated_output_tone_out(tone),
    .regulated_output_ramping_out(ramping), .regulated_output_ready_out(ready),
    .regulated_output_high_out(high));
  tgc_assertions #(.RAMP_LOW_CYCLES(100), .RAMP_HIGH_CYCLES(150)) i_tgc_assertions (.clk_in(clk_in),
    .rstn_in(rstn_in), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr),
    .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata), .tone_control_input(link.tone_control_input),
    .regulated_output_tone_out(tone), .regulated_output_ramping_out(ramping),
    .regulated_output_ready_out(ready));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // a zero mask only fetches the byte into rv, for polling
  task automatic rd(input logic [7:0] a, input logic [7:0] e = 8'h00, input logic [7:0] m = 8'h00);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    rv = rdata_out;
    if (m != 8'h00) chk($sformatf("read %h", a), e, rv & m);
  endtask : rd
  function automatic logic sel(input int s);
    case (s)
      0: return tone;
      1: return ramping;
      2: return ready;
      default: return link.tone_control_input;
    endcase
  endfunction : sel
  task automatic wt(input int s, input logic v, input int lim);
    n = 0;
    #1;
    while (sel(s) !== v) begin
      if (n >= lim) begin
        chk($sformatf("wait %0d", s), {7'h00, v}, {7'h00, sel(s)});
        finish_test();
      end
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask : wt
  task automatic idle();
    n = 0;
    do begin
      rd(HOST_STATUS_ADDR);
      n++;
    end while (rv[1:0] !== 2'h0 && n < 10);
    chk("host idle", 8'h00, {6'h00, rv[1:0]});
  endtask : idle

  initial begin
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(HOST_MODE_ADDR, HOST_MODE_RESET, 8'hff);
    rd(8'h20, 8'h00, 8'hff);
    for (int i = 2; i <= 5; i++) begin
      rd(HOST_FWD_BASE + 8'(i), CONTROL_RESET, 8'hff);
      wr(HOST_FWD_BASE + 8'(i), {3'h5, 3'(i), 2'h0});
      rd(HOST_FWD_BASE + 8'(i), {3'h5, 3'(i), 2'h0}, 8'hff);
      wr(HOST_FWD_BASE + 8'(i), 8'h00);
    end
    wr(HOST_FWD_BASE, 8'hff);
    wr(HOST_FWD_BASE + 8'h01, 8'hff);
    rd(HOST_FWD_BASE, 8'h00, 8'hff);
    rd(HOST_FWD_BASE + 8'h01, 8'h00, 8'hff);
    wr(HOST_FWD_BASE + CONTROL_WORD_A_ADDR, 8'h01);
    wt(1, 1'b1, 5);
    wt(2, 1'b1, 300);
    chk("ramp low", 8'h01, {7'h00, (n inside {[95:105]})});
    rd(HOST_FWD_BASE + 8'h01, 8'h01, 8'hff);
    wr(HOST_FWD_BASE + CONTROL_WORD_A_ADDR, 8'h03);
    wt(1, 1'b1, 5);
    wt(2, 1'b1, 400);
    chk("ramp high", 8'h01, {7'h00, (n inside {[145:155]})});
    chk("high level", 8'h01, {7'h00, high});
    // continuous carrier: line held high, enable bit alone gates
    wr(HOST_MODE_ADDR, 8'h07);
    wt(0, 1'b1, 3000);
    chk("cont start", 8'h01, {7'h00, (n >= 300)});
    rd(HOST_FWD_BASE, 8'h04, 8'h06);
    // enable cleared while the line is still held high
    wr(HOST_FWD_BASE + CONTROL_WORD_B_ADDR, 8'h00);
    n = 0;
    repeat (2400) begin
      @(posedge clk_in);
      #1;
      if (tone !== 1'b0) n++;
    end
    chk("tone off", 8'h00, {7'h00, (n != 0)});
    wr(HOST_MODE_ADDR, 8'h03);
    idle();
    rd(HOST_FWD_BASE + CONTROL_WORD_B_ADDR, 8'h00, 8'hff);
    // envelope gating an internal carrier
    wr(HOST_MODE_ADDR, 8'h0e);
    wt(0, 1'b1, 3000);
    chk("env start", 8'h01, {7'h00, (n >= 300)});
    wr(HOST_MODE_ADDR, 8'h06);
    n = 0;
    do begin
      rd(HOST_FWD_BASE);
      n += 2;
    end while (rv[ST_GATE_BIT] !== 1'b0 && n < 4000);
    chk("env stop", 8'h01, {7'h00, (n inside {[740:3010]})});
    wr(HOST_MODE_ADDR, 8'h02);
    idle();
    // external square wave; host sets both bits before driving the line
    wr(HOST_MODE_ADDR, 8'h05);
    wt(3, 1'b1, 3000);
    wt(0, 1'b1, 100);
    chk("ext start", 8'h01, {7'h00, (n inside {[45:56]})});
    wt(3, 1'b0, 1300);
    repeat (2) @(posedge clk_in);
    #1;
    chk("ext lag", 8'h01, {7'h00, tone});
    repeat (2) @(posedge clk_in);
    #1;
    chk("ext fall", 8'h00, {7'h00, tone});
    // line parked high with both bits kept: gate must close once edges cease
    wr(HOST_MODE_ADDR, 8'h0e);
    n = 0;
    do begin
      rd(HOST_FWD_BASE);
      n += 2;
    end while (rv[ST_GATE_BIT] !== 1'b0 && n < 4000);
    chk("ext stop", 8'h01, {7'h00, (n inside {[2990:3020]})});
    wr(HOST_MODE_ADDR, 8'h01);
    idle();
    rd(HOST_FWD_BASE + CONTROL_WORD_B_ADDR, 8'h00, 8'hff);
    finish_test();
  end
endmodule : tone_gating_control_tb
`default_nettype wire
